// ---- timer_input_capture.v ----
// Two-channel input capture unit of a 16-bit timer with a classic Wishbone register slave.
//
// Behaviour
// RULE1: two channels latch the 16-bit counter on the active pin transition.
// RULE2: capture registers are read-only, presented as high and low bytes.
// RULE3: per channel, an edge-select bit picks rising or falling as active.
// RULE4: resolution is one counter count; counter rate set by two-bit prescaler field.
// RULE5: channel 2 edge in control 2; channel 1 edge and irq enable in control 1.
// RULE6: a capture sets the channel flag and loads the counter value.
// RULE7: interrupt when enable set and CPU mask clear; otherwise it stays pending.
// RULE8: flag clears after status read with flag set, then low-byte access.
// RULE9: reading the high byte blocks captures until the low byte is read.
// RULE10: the capture register holds the most recent capture value.
// RULE11: both channels work together, regardless of output compare use.
// RULE12: in one-pulse or PWM mode only channel 2 captures.
// RULE13: pins always feed capture; high-byte read is the way to disable.
// RULE14: overflow flag with its interrupt lets software extend the range.
// RULE15: pins are synchronised and edges found on the synchronised signal.
//
// Register access over Wishbone and the placing of the registers were left to the implementer.
`include "timer_input_capture_consts.vh"

module timer_input_capture (
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    input  wire        wb_we_i,
    input  wire [7:0]  wb_adr_i,
    input  wire [3:0]  wb_sel_i,
    input  wire [31:0] wb_dat_i,
    output wire [31:0] wb_dat_o,
    output wire        wb_ack_o,
    input  wire        capture_pin_1_i,
    input  wire        capture_pin_2_i,
    input  wire        cpu_irq_mask_i,
    output wire        timer_irq_o
);

    // ------------------------------------------------------------------------
    // Address decoding
    // ------------------------------------------------------------------------
    function hit;
        input [7:0] adr;
        input [7:0] ofs;
        begin
            hit = (adr == ofs);
        end
    endfunction

    reg         ack_r;
    reg  [7:0]  dat_r;
    wire        take;
    wire        rd;
    wire        wr;

    // A request is taken only while ack is low, so a strobe still high in its ack cycle is not served twice.
    assign take = wb_cyc_i & wb_stb_i & ~ack_r;
    assign rd   = take & ~wb_we_i;
    assign wr   = take & wb_we_i & wb_sel_i[0];

    // ------------------------------------------------------------------------
    // Access strobes
    // ------------------------------------------------------------------------
    wire rd_status = rd & hit(wb_adr_i, `OFS_STATUS);
    wire acc_cnt_l = take & hit(wb_adr_i, `OFS_COUNT_LOW);

    // ------------------------------------------------------------------------
    // Capture register offsets
    // ------------------------------------------------------------------------
    // Channel register offset; low selects the low byte of the pair.
    function [7:0] cap_ofs;
        input chan;
        input low;
        begin
            case ({chan, low})
                2'b00:   cap_ofs = `OFS_CAP1_HIGH;
                2'b01:   cap_ofs = `OFS_CAP1_LOW;
                2'b10:   cap_ofs = `OFS_CAP2_HIGH;
                default: cap_ofs = `OFS_CAP2_LOW;
            endcase
        end
    endfunction

    // Per-channel strobes, bit 0 for channel 1 and bit 1 for channel 2.
    wire [1:0] rd_high;
    wire [1:0] rd_low;
    wire [1:0] acc_low;
    assign rd_high = {rd & hit(wb_adr_i, cap_ofs(1'b1, 1'b0)), rd & hit(wb_adr_i, cap_ofs(1'b0, 1'b0))};
    assign rd_low  = {rd & hit(wb_adr_i, cap_ofs(1'b1, 1'b1)), rd & hit(wb_adr_i, cap_ofs(1'b0, 1'b1))};
    assign acc_low = {take & hit(wb_adr_i, cap_ofs(1'b1, 1'b1)), take & hit(wb_adr_i, cap_ofs(1'b0, 1'b1))};

    // ------------------------------------------------------------------------
    // Control registers
    // ------------------------------------------------------------------------
    reg [7:0] timer_control_1_r;
    reg [7:0] timer_control_2_r;
    reg [7:0] timer_control_1_nxt;
    reg [7:0] timer_control_2_nxt;

    // Capture registers have no write path; writes to them only count as accesses.
    always @* begin // see RULE2
        timer_control_1_nxt = timer_control_1_r;
        timer_control_2_nxt = timer_control_2_r;
        if (wr && hit(wb_adr_i, `OFS_CONTROL_1)) begin // see RULE5
            timer_control_1_nxt = wb_dat_i[7:0];
        end
        if (wr && hit(wb_adr_i, `OFS_CONTROL_2)) begin // see RULE5
            timer_control_2_nxt = wb_dat_i[7:0];
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer_control_1_r <= `RST_CONTROL;
            timer_control_2_r <= `RST_CONTROL;
        end else begin
            timer_control_1_r <= timer_control_1_nxt;
            timer_control_2_r <= timer_control_2_nxt;
        end
    end

    wire       capture_irq_enable  = timer_control_1_r[`BIT_C1_CAP_IRQ_EN];
    wire       overflow_irq_enable = timer_control_1_r[`BIT_C1_OVF_IRQ_EN];
    // Edge select 1 picks rising transitions, 0 picks falling ones.
    wire [1:0] edge_select = {timer_control_2_r[`BIT_C2_EDGE_2], timer_control_1_r[`BIT_C1_EDGE_1]};
    wire [1:0] timer_prescale_select = timer_control_2_r[`BIT_C2_PRESC_HI:`BIT_C2_PRESC_LO];
    // Either timer output mode claims channel 1, so its captures are blocked there.
    wire       pulse_mode = timer_control_2_r[`BIT_C2_ONE_PULSE] | timer_control_2_r[`BIT_C2_PWM];

    // ------------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------------
    wire [15:0] count;
    wire        overflow;

    timer_count_base u_count (
        .clk_sys_i         (clk_sys_i),
        .rst_n_i           (rst_n_i),
        .prescale_select_i (timer_prescale_select),
        .count_o           (count),
        .overflow_o        (overflow)
    );

    // ------------------------------------------------------------------------
    // Capture channels
    // ------------------------------------------------------------------------
    wire [1:0]  pins = {capture_pin_2_i, capture_pin_1_i};
    wire [1:0]  cap_event;
    wire [1:0]  cap_allowed;
    wire [1:0]  capture_flag;
    wire [1:0]  clear_armed;
    wire [1:0]  inhibit;
    wire [15:0] capture_value [0:1];

    // Channel 1 is taken over by one-pulse and PWM operation; channel 2 never is.
    assign cap_allowed = {~inhibit[1], ~inhibit[0] & ~pulse_mode}; // see RULE12

    // Channels share only the counter, so both may capture in one cycle.
    genvar ch;
    generate
        for (ch = 0; ch < 2; ch = ch + 1) begin : g_chan
            reg  [15:0] value_r;
            reg         flag_r;
            reg         flag_nxt;
            reg         armed_r;
            reg         armed_nxt;
            reg         hold_r;
            reg         inhibit_nxt;
            wire        do_capture;
            wire        clr;

            // Pins reach the detector unconditionally, whatever their pad direction.
            capture_edge_detect u_edge ( // see RULE13
                .clk_sys_i     (clk_sys_i),
                .rst_n_i       (rst_n_i),
                .pin_i         (pins[ch]),
                .edge_select_i (edge_select[ch]),
                .event_o       (cap_event[ch])
            );

            assign do_capture = cap_event[ch] & cap_allowed[ch]; // see RULE9
            assign clr        = clear_armed[ch] & acc_low[ch]; // see RULE8

            // Each capture overwrites the previous value; channels run independently.
            always @(posedge clk_sys_i or negedge rst_n_i) begin // see RULE1 RULE11
                if (!rst_n_i) begin
                    value_r <= `RST_CAPTURE;
                end else if (do_capture) begin
                    value_r <= count; // see RULE10
                end
            end

            // A capture in the cycle of the clearing access wins over the clear.
            always @* begin
                flag_nxt  = flag_r;
                armed_nxt = armed_r;
                if (do_capture) begin
                    flag_nxt  = 1'b1; // see RULE6
                    armed_nxt = 1'b0;
                end else if (clr) begin
                    flag_nxt  = 1'b0; // see RULE8
                    armed_nxt = 1'b0;
                end else if (rd_status & flag_r) begin
                    armed_nxt = 1'b1; // see RULE8
                end
            end

            // Reading the high byte freezes the pair so both bytes belong together.
            always @* begin // see RULE9
                inhibit_nxt = hold_r;
                if (rd_low[ch]) begin
                    inhibit_nxt = 1'b0;
                end else if (rd_high[ch]) begin
                    inhibit_nxt = 1'b1;
                end
            end

            always @(posedge clk_sys_i or negedge rst_n_i) begin
                if (!rst_n_i) begin
                    flag_r  <= 1'b0;
                    armed_r <= 1'b0;
                    hold_r  <= 1'b0;
                end else begin
                    flag_r  <= flag_nxt;
                    armed_r <= armed_nxt;
                    hold_r  <= inhibit_nxt;
                end
            end

            assign capture_value[ch] = value_r;
            assign capture_flag[ch]  = flag_r;
            assign clear_armed[ch]   = armed_r;
            assign inhibit[ch]       = hold_r;
        end
    endgenerate

    // ------------------------------------------------------------------------
    // Overflow flag
    // ------------------------------------------------------------------------
    reg  timer_overflow_flag_r;
    reg  ovf_armed_r;
    reg  ovf_flag_nxt;
    reg  ovf_armed_nxt;
    wire ovf_clr = ovf_armed_r & acc_cnt_l;

    // Same two-step clearing as the capture flags, through the counter low byte.
    always @* begin // see RULE14
        ovf_flag_nxt  = timer_overflow_flag_r;
        ovf_armed_nxt = ovf_armed_r;
        if (overflow) begin
            ovf_flag_nxt  = 1'b1;
            ovf_armed_nxt = 1'b0;
        end else if (ovf_clr) begin
            ovf_flag_nxt  = 1'b0;
            ovf_armed_nxt = 1'b0;
        end else if (rd_status & timer_overflow_flag_r) begin
            ovf_armed_nxt = 1'b1;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            timer_overflow_flag_r <= 1'b0;
            ovf_armed_r           <= 1'b0;
        end else begin
            timer_overflow_flag_r <= ovf_flag_nxt;
            ovf_armed_r           <= ovf_armed_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Interrupt
    // ------------------------------------------------------------------------
    reg irq_r;
    reg irq_nxt;

    // Flags stay set while masked, so the request is simply held until unmasked.
    always @* begin // see RULE7
        irq_nxt = ~cpu_irq_mask_i & ((capture_irq_enable & (|capture_flag)) |
                                     (overflow_irq_enable & timer_overflow_flag_r)); // see RULE14
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_r <= 1'b0;
        end else begin
            irq_r <= irq_nxt;
        end
    end

    assign timer_irq_o = irq_r;

    // ------------------------------------------------------------------------
    // Read data and acknowledge
    // ------------------------------------------------------------------------
    wire [7:0] timer_status_reg = {5'h00, timer_overflow_flag_r, capture_flag};
    reg  [7:0] rdata;

    // Unmapped offsets read as zero so software can probe the map safely.
    always @* begin
        case (wb_adr_i)
            `OFS_CONTROL_1:  rdata = timer_control_1_r;
            `OFS_CONTROL_2:  rdata = timer_control_2_r;
            `OFS_STATUS:     rdata = timer_status_reg;
            `OFS_CAP1_HIGH:  rdata = capture_value[0][15:8]; // see RULE2
            `OFS_CAP1_LOW:   rdata = capture_value[0][7:0];
            `OFS_CAP2_HIGH:  rdata = capture_value[1][15:8];
            `OFS_CAP2_LOW:   rdata = capture_value[1][7:0];
            `OFS_COUNT_HIGH: rdata = count[15:8];
            `OFS_COUNT_LOW:  rdata = count[7:0];
            default:         rdata = 8'h00;
        endcase
    end

    reg       ack_nxt;
    reg [7:0] dat_nxt;

    // Every access, mapped or not, is answered one cycle after it is taken.
    // Read data is held after the ack so a slow master can still pick it up.
    always @* begin
        ack_nxt = take;
        dat_nxt = dat_r;
        if (rd) begin
            dat_nxt = rdata;
        end
    end

    always @(posedge clk_sys_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_r <= 1'b0;
            dat_r <= 8'h00;
        end else begin
            ack_r <= ack_nxt;
            dat_r <= dat_nxt;
        end
    end

    assign wb_ack_o = ack_r;
    assign wb_dat_o = {24'h00_0000, dat_r};

endmodule // timer_input_capture

// ---- timer_input_capture_consts.vh ----
// Register offsets, field positions, reset values and prescaler constants of the input capture block.
`ifndef TIMER_INPUT_CAPTURE_CONSTS_VH
`define TIMER_INPUT_CAPTURE_CONSTS_VH

// ----------------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------------
`define OFS_CONTROL_1          8'h00
`define OFS_CONTROL_2          8'h04
`define OFS_STATUS             8'h08
`define OFS_CAP1_HIGH          8'h0C
`define OFS_CAP1_LOW           8'h10
`define OFS_CAP2_HIGH          8'h14
`define OFS_CAP2_LOW           8'h18
`define OFS_COUNT_HIGH         8'h1C
`define OFS_COUNT_LOW          8'h20

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define BIT_C1_EDGE_1          1
`define BIT_C1_OVF_IRQ_EN      5
`define BIT_C1_CAP_IRQ_EN      7
`define BIT_C2_EDGE_2          1
`define BIT_C2_PRESC_LO        2
`define BIT_C2_PRESC_HI        3
`define BIT_C2_PWM             4
`define BIT_C2_ONE_PULSE       5
`define BIT_ST_FLAG_1          0
`define BIT_ST_FLAG_2          1
`define BIT_ST_OVF             2

// ----------------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------------
`define RST_CONTROL            8'h00
`define RST_CAPTURE            16'h0000
`define RST_COUNT              16'hFFFC
`define RST_PRESC              4'h0

// ----------------------------------------------------------------------------
// Prescaler: the divide ratio is 2 shifted left by the select field.
// ----------------------------------------------------------------------------
`define PRESC_BASE             5'h02

`endif

// ---- capture_edge_detect.v ----
// Capture pin synchroniser and programmable edge detector.
module capture_edge_detect (
    input  wire clk_sys_i,
    input  wire rst_n_i,
    input  wire pin_i,
    input  wire edge_select_i,
    output wire event_o
);

    reg sync_meta_r;
    reg sync_r;
    reg prev_r;

    // The first stage feeds only the second; edges are seen on the settled copy.
    always @(posedge clk_sys_i or negedge rst_n_i) begin // see RULE15
        if (!rst_n_i) begin
            sync_meta_r <= 1'b0;
            sync_r      <= 1'b0;
            prev_r      <= 1'b0;
        end else begin
            sync_meta_r <= pin_i;
            sync_r      <= sync_meta_r;
            prev_r      <= sync_r;
        end
    end

    // Edge select high picks rising transitions, low picks falling ones.
    assign event_o = edge_select_i ? (sync_r & ~prev_r) : (~sync_r & prev_r); // see RULE3

endmodule // capture_edge_detect

// ---- timer_count_base.v ----
// Prescaler and 16-bit free-running counter that the captures sample.
`include "timer_input_capture_consts.vh"

module timer_count_base (
    input  wire        clk_sys_i,
    input  wire        rst_n_i,
    input  wire [1:0]  prescale_select_i,
    output wire [15:0] count_o,
    output wire        overflow_o
);

    reg  [3:0]  presc_r;
    reg  [15:0] count_r;
    wire [4:0]  ratio;
    wire        tick;

    assign ratio = `PRESC_BASE << prescale_select_i;
    assign tick  = (presc_r == (ratio[3:0] - 4'h1)) | (ratio == 5'h10 && presc_r == 4'hF);

    // One count per prescaled period sets the capture resolution.
    always @(posedge clk_sys_i or negedge rst_n_i) begin // see RULE4
        if (!rst_n_i) begin
            presc_r <= `RST_PRESC;
            count_r <= `RST_COUNT;
        end else begin
            presc_r <= tick ? `RST_PRESC : presc_r + 4'h1;
            if (tick) begin
                count_r <= count_r + 16'h0001;
            end
        end
    end

    assign count_o    = count_r;
    assign overflow_o = tick & (count_r == 16'hFFFF);

endmodule // timer_count_base

// ---- capture_source.sv ----
// Behavioural source of the waveforms on the two capture pins.
module capture_source (
    input  wire        clk_sys_i,
    output logic [1:0] pin_o
);
    timeunit 1ns;
    timeprecision 1ns;
    initial pin_o = 2'b00;
    // Pins change only just after an edge and hold each level for at least one clock.
    task automatic drive(input logic [1:0] sel, input logic lvl, input int hold);
        @(posedge clk_sys_i);
        pin_o <= (pin_o & ~sel) | (sel & {2{lvl}});
        repeat (hold) @(posedge clk_sys_i);
    endtask
endmodule // capture_source

// ---- timer_input_capture_properties.sv ----
// Port assertions for the input capture block.
`include "timer_input_capture_consts.vh"
module timer_input_capture_properties (
    input wire        clk_sys_i,
    input wire        rst_n_i,
    input wire        wb_cyc_i,
    input wire        wb_stb_i,
    input wire        wb_we_i,
    input wire [7:0]  wb_adr_i,
    input wire [3:0]  wb_sel_i,
    input wire [31:0] wb_dat_i,
    input wire [31:0] wb_dat_o,
    input wire        wb_ack_o,
    input wire        capture_pin_1_i,
    input wire        capture_pin_2_i,
    input wire        cpu_irq_mask_i,
    input wire        timer_irq_o
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (!rst_n_i);
    chk_ack_on_time: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("late ack");
    chk_ack_one_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("long ack");
    chk_ack_has_cause: assert property (!(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    chk_dat_upper_zero: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    chk_dat_stands: assert property ($changed(wb_dat_o) |-> wb_ack_o)
        else $error("read data moved");
    chk_status_spare: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == `OFS_STATUS
        |-> wb_dat_o[7:3] == 5'h00) else $error("spare status bits set");
    chk_unmapped_zero: assert property (wb_ack_o && !$past(wb_we_i) && $past(wb_adr_i) == 8'hFC
        |-> wb_dat_o == 32'h0000_0000) else $error("unmapped read not zero");
    chk_irq_masked: assert property (cpu_irq_mask_i |=> !timer_irq_o)
        else $error("irq while masked");
    chk_irq_pending: assert property (timer_irq_o && !cpu_irq_mask_i && !wb_cyc_i |=> timer_irq_o)
        else $error("irq dropped without access");
    cov_read: cover property (wb_ack_o && !wb_we_i);
    cov_irq: cover property ($rose(timer_irq_o));
    cov_unmask: cover property (cpu_irq_mask_i ##1 !cpu_irq_mask_i ##2 timer_irq_o);
endmodule // timer_input_capture_properties

bind timer_input_capture timer_input_capture_properties u_props (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .capture_pin_1_i(capture_pin_1_i), .capture_pin_2_i(capture_pin_2_i), .cpu_irq_mask_i(cpu_irq_mask_i),
    .timer_irq_o(timer_irq_o));

// ---- timer_input_capture_tb.sv ----
// Wishbone bench for the input capture block, checked against a behavioural model.
`include "timer_input_capture_consts.vh"
module timer_input_capture_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic        clk_sys_i = 1'b0, rst_n_i = 1'b0, cyc = 1'b0, we = 1'b0, mask = 1'b0, ack, irq;
    logic [7:0]  adr = 8'h00, wdat = 8'h00, m_c1 = 8'h00, m_c2 = 8'h00;
    logic [1:0]  pins, m_f = 2'b00, m_arm = 2'b00, m_inh = 2'b00;
    logic [31:0] rdat, q;
    logic [15:0] v1, v2;
    int          error_cnt = 0, samples_checked = 0, g, r;

    timer_input_capture u_dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .wb_cyc_i(cyc), .wb_stb_i(cyc),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'h1), .wb_dat_i({24'h00_0000, wdat}), .wb_dat_o(rdat),
        .wb_ack_o(ack), .capture_pin_1_i(pins[0]), .capture_pin_2_i(pins[1]), .cpu_irq_mask_i(mask),
        .timer_irq_o(irq));
    capture_source u_src (.clk_sys_i(clk_sys_i), .pin_o(pins));

    initial forever #50 clk_sys_i = ~clk_sys_i;

    task automatic end_of_test;
        if (error_cnt == 0 && samples_checked > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic fail(input string s);
        error_cnt++;
        $display("mismatch at %0t: %s", $time, s);
    endtask
    task automatic cmp_reg(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) fail($sformatf("read %h, expected %h", got, exp));
    endtask
    // Sampled on falling edges so the registered interrupt has settled.
    task automatic chk_irq;
        repeat (2) @(negedge clk_sys_i);
        samples_checked++;
        if (irq !== (!mask && m_c1[7] && |m_f)) fail("interrupt level");
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        cyc <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (ack !== 1'b1 && n < 20);
        if (ack !== 1'b1) fail("no ack");
        q = rdat;
        cyc <= 1'b0;
        if (!w && a == `OFS_STATUS) m_arm = m_arm | m_f;
        for (int i = 0; i < 2; i++) begin
            if (a == (i ? `OFS_CAP2_LOW : `OFS_CAP1_LOW)) begin
                m_f[i] = m_f[i] & !m_arm[i];
                m_arm[i] = 1'b0;
                m_inh[i] = m_inh[i] & w;
            end
            if (!w && a == (i ? `OFS_CAP2_HIGH : `OFS_CAP1_HIGH)) m_inh[i] = 1'b1;
        end
        if (w && a == `OFS_CONTROL_1) m_c1 = d;
        if (w && a == `OFS_CONTROL_2) m_c2 = d;
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [31:0] mk = 32'hFFFF_FFFF);
        bus(1'b0, a, 8'h00);
        cmp_reg(q & mk, e);
    endtask
    // The overflow flag runs on its own, so its bit is masked out here.
    task automatic st;
        rd(`OFS_STATUS, {30'h0, m_f}, 32'hFFFF_FFFB);
    endtask
    task automatic cap(input int i, output logic [15:0] v);
        bus(1'b0, i ? `OFS_CAP2_HIGH : `OFS_CAP1_HIGH, 8'h00);
        v[15:8] = q[7:0];
        bus(1'b0, i ? `OFS_CAP2_LOW : `OFS_CAP1_LOW, 8'h00);
        v[7:0] = q[7:0];
    endtask
    task automatic edge_on(input logic [1:0] ch, input logic lvl, input int hold);
        for (int i = 0; i < 2; i++)
            if (ch[i] && pins[i] !== lvl && lvl == (i ? m_c2[1] : m_c1[1]) && !m_inh[i]
                && !(i == 0 && (m_c2[4] || m_c2[5]))) begin
                m_f[i] = 1'b1;
                m_arm[i] = 1'b0;
            end
        u_src.drive(ch, lvl, hold);
    endtask

    initial begin
        logic [7:0] ra [7];
        ra = '{`OFS_CONTROL_1, `OFS_CONTROL_2, `OFS_CAP1_HIGH, `OFS_CAP1_LOW, `OFS_CAP2_HIGH, `OFS_CAP2_LOW, 8'hFC};
        void'($urandom(63));
        repeat (16) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        foreach (ra[k]) rd(ra[k], 32'h0000_0000);
        st();
        bus(1'b1, `OFS_CONTROL_1, 8'h82);
        bus(1'b1, `OFS_CONTROL_2, 8'h02);
        bus(1'b1, `OFS_CAP1_HIGH, 8'h5A);
        rd(`OFS_CONTROL_1, m_c1);
        rd(`OFS_CONTROL_2, m_c2);
        rd(`OFS_CAP1_HIGH, 32'h0000_0000);
        rd(`OFS_CAP1_LOW, 32'h0000_0000);
        mask <= 1'b1;
        edge_on(2'b11, 1'b1, 5);
        chk_irq();
        bus(1'b1, `OFS_CAP2_LOW, 8'h00);
        st();
        mask <= 1'b0;
        chk_irq();
        cap(0, v1);
        cap(1, v2);
        cmp_reg({16'h0000, v2}, {16'h0000, v1});
        chk_irq();
        bus(1'b1, `OFS_CONTROL_1, 8'h80);
        edge_on(2'b01, 1'b0, 5);
        st();
        bus(1'b1, `OFS_CAP1_LOW, 8'h00);
        edge_on(2'b01, 1'b1, 5);
        st();
        bus(1'b0, `OFS_CAP1_HIGH, 8'h00);
        edge_on(2'b01, 1'b0, 5);
        st();
        bus(1'b0, `OFS_CAP1_LOW, 8'h00);
        edge_on(2'b01, 1'b1, 5);
        edge_on(2'b01, 1'b0, 5);
        st();
        bus(1'b1, `OFS_CONTROL_1, 8'h82);
        for (int m = 4; m < 6; m++) begin
            bus(1'b1, `OFS_CAP1_LOW, 8'h00);
            bus(1'b1, `OFS_CONTROL_2, 8'h02 | (8'h01 << m));
            edge_on(2'b11, 1'b0, 1);
            edge_on(2'b11, 1'b1, 5);
            st();
        end
        bus(1'b1, `OFS_CONTROL_1, 8'h82);
        for (int s = 0; s < 4; s++) begin
            bus(1'b1, `OFS_CONTROL_2, 8'h02 | 8'(s << 2));
            g = 8 + $urandom % 33;
            r = 2 << s;
            edge_on(2'b11, 1'b0, 1);
            edge_on(2'b01, 1'b1, g - 1);
            edge_on(2'b10, 1'b1, 5);
            cap(0, v1);
            cap(1, v2);
            cmp_reg({31'h0, int'(v2 - v1) * r > g - r && int'(v2 - v1) * r < g + r}, 32'h1);
        end
        end_of_test();
    end

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        fail("watchdog expired");
        end_of_test();
    end
endmodule // timer_input_capture_tb
